// ---- hdl/workspace_call_linkage.sv ----
// Purpose: Call, return, context switch and trap sequencer of a memory
//   resident register machine.
// Assumes: Memory answers each request with memAck, read data with it.
// Notes: One command at a time; cmdReady high means idle.
// Function
// RULE1 - Call with link writes return address to register eleven, jumps.
// RULE2 - Each call with link overwrites register eleven; no hidden stack.
// RULE3 - Indirect branch loads PC from the named workspace register.
// RULE4 - Auto increment: access with old value, then advance register.
// RULE5 - Context switch loads new workspace pointer before transferring.
// RULE6 - Caller workspace pointer stored in register thirteen of new one.
// RULE7 - Context return restores caller workspace pointer.
// RULE8 - Byte access to a register uses its left byte.
// RULE9 - Memory moves whole words; core selects the byte internally.
// RULE10 - Address bus carries fifteen word address bits only.
// RULE11 - Sixteen trap numbers, each with a two word vector.
// RULE12 - Trap vector I lies at bytes 40+4I to 43+4I hex.
// RULE13 - Trap fifteen reads its vector from bytes 7C to 7F.
// RULE14 - Trap acts as context switch and writes source address to R11.
// RULE15 - Register x lives at workspace pointer plus two times x.
// RULE16 - Only PC, status and workspace pointer are held inside.
// RULE17 - Context switch saves caller PC and status in R14 and R15.
`timescale 1ns/100ps
`default_nettype none
module workspace_call_linkage
  import wsp_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Command port
  input wire cmd_s cmd,
  input wire logic cmdValid,
  output logic cmdReady,
  output logic [15:0] opndData,
  output logic opndValid,
  // Memory port
  output mem_req_s memReq,
  input wire logic memAck,
  input wire logic [15:0] memRdata,
  // Visible internal state
  output logic [15:0] pcOut,
  output logic [15:0] wpOut,
  output logic [15:0] stOut
);

  typedef enum logic [3:0] {
    S_IDLE, S_LINK_WR, S_RD_REG, S_RD_OPND, S_INC_WR,
    S_VEC_WP, S_VEC_PC, S_SAVE_WP, S_SAVE_PC, S_SAVE_ST, S_SAVE_SRC,
    S_RST_ST, S_RST_PC, S_RST_WP
  } state_e;

  // ****************************************
  // Address helpers
  // ****************************************
  // Byte address of workspace register x.
  function automatic logic [15:0] regAddr(input logic [15:0] wp,
                                          input logic [3:0] x);
    regAddr = wp + REG_STRIDE * {12'h000, x}; // see RULE15
  endfunction

  // Byte address of trap vector word.
  function automatic logic [15:0] vecAddr(input logic [3:0] n);
    vecAddr = TRAP_VEC_BASE + TRAP_VEC_STEP * {12'h000, n}; // see RULE12
  endfunction

  // The only program state registers; the general registers stay in memory.
  logic [15:0] pc_ff, wp_ff, st_ff; // see RULE16
  logic [15:0] newWp_ff, newPc_ff, regVal_ff;
  cmd_s cmd_ff;
  state_e state_ff;
  logic busy_ff;

  // Request kept high until acknowledged.
  wire logic done = memReq.req & memAck;

  // ****************************************
  // Sequencer
  // ****************************************
  // Issues one memory word per state; a state leaves on its acknowledge.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= S_IDLE;
      cmd_ff <= '0;
    end else begin
      case (state_ff)
        S_IDLE: begin
          if (cmdValid && cmdReady) begin
            cmd_ff <= cmd;
            case (cmd.op)
              OP_CALL_LINK: state_ff <= S_LINK_WR; // see RULE1
              OP_RET_INDIRECT, OP_READ_OPND: state_ff <= S_RD_REG;
              OP_CTX_CALL, OP_TRAP: state_ff <= S_VEC_WP;
              OP_CTX_RETURN: state_ff <= S_RST_ST; // see RULE7
              default: state_ff <= S_IDLE;
            endcase
          end
        end
        S_LINK_WR: if (done) state_ff <= S_IDLE;
        S_RD_REG: begin
          if (done) begin
            if (cmd_ff.op == OP_RET_INDIRECT || cmd_ff.mode == MODE_REG) begin
              state_ff <= S_IDLE;
            end else begin
              state_ff <= S_RD_OPND;
            end
          end
        end
        S_RD_OPND: begin
          if (done) begin
            state_ff <= (cmd_ff.mode == MODE_IND_INC) ? S_INC_WR : S_IDLE;
          end
        end
        S_INC_WR: if (done) state_ff <= S_IDLE; // see RULE4
        S_VEC_WP: if (done) state_ff <= S_VEC_PC;
        S_VEC_PC: if (done) state_ff <= S_SAVE_WP;
        S_SAVE_WP: if (done) state_ff <= S_SAVE_PC;
        S_SAVE_PC: if (done) state_ff <= S_SAVE_ST;
        S_SAVE_ST: begin
          if (done) begin
            state_ff <= (cmd_ff.op == OP_TRAP) ? S_SAVE_SRC : S_IDLE;
          end
        end
        S_SAVE_SRC: if (done) state_ff <= S_IDLE;
        S_RST_ST: if (done) state_ff <= S_RST_PC;
        S_RST_PC: if (done) state_ff <= S_RST_WP;
        S_RST_WP: if (done) state_ff <= S_IDLE;
        default: state_ff <= S_IDLE;
      endcase
    end
  end

  // ****************************************
  // Memory request
  // ****************************************
  logic [15:0] byteAddr;
  logic [15:0] wrWord;
  logic wrEn, reqEn;
  logic [3:0] vecSel;

  // Context switch uses slot 0 of a table given by target; trap its number.
  always_comb begin
    vecSel = cmd_ff.trapNum;
    byteAddr = '0;
    wrWord = '0;
    wrEn = 1'b0;
    reqEn = 1'b1;
    case (state_ff)
      S_LINK_WR: begin
        byteAddr = regAddr(wp_ff, LINK_REG); // see RULE2
        wrWord = pc_ff;
        wrEn = 1'b1;
      end
      S_RD_REG: byteAddr = regAddr(wp_ff, cmd_ff.regNum);
      S_RD_OPND: byteAddr = regVal_ff; // see RULE4
      S_INC_WR: begin
        byteAddr = regAddr(wp_ff, cmd_ff.regNum);
        wrWord = regVal_ff + (cmd_ff.isByte ? BYTE_STEP : WORD_STEP);
        wrEn = 1'b1;
      end
      S_VEC_WP: begin
        byteAddr = (cmd_ff.op == OP_TRAP) ? vecAddr(vecSel) : cmd_ff.target;
      end
      S_VEC_PC: begin
        byteAddr = ((cmd_ff.op == OP_TRAP) ? vecAddr(vecSel)
                    : cmd_ff.target) + WORD_STEP; // see RULE13
      end
      S_SAVE_WP: begin
        byteAddr = regAddr(newWp_ff, SAVED_WP_REG); // see RULE6
        wrWord = wp_ff;
        wrEn = 1'b1;
      end
      S_SAVE_PC: begin
        byteAddr = regAddr(newWp_ff, SAVED_PC_REG); // see RULE17
        wrWord = pc_ff;
        wrEn = 1'b1;
      end
      S_SAVE_ST: begin
        byteAddr = regAddr(newWp_ff, SAVED_ST_REG); // see RULE17
        wrWord = st_ff;
        wrEn = 1'b1;
      end
      S_SAVE_SRC: begin
        byteAddr = regAddr(newWp_ff, LINK_REG); // see RULE14
        wrWord = cmd_ff.target;
        wrEn = 1'b1;
      end
      S_RST_ST: byteAddr = regAddr(wp_ff, SAVED_ST_REG);
      S_RST_PC: byteAddr = regAddr(wp_ff, SAVED_PC_REG);
      S_RST_WP: byteAddr = regAddr(wp_ff, SAVED_WP_REG);
      default: reqEn = 1'b0;
    endcase
  end

  // Registered request; dropped for one cycle after each acknowledge so a
  // stale acknowledge cannot complete the next word.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      memReq <= '0;
    end else begin
      memReq.req <= reqEn & ~done;
      memReq.write <= wrEn;
      memReq.addr <= byteAddr[15:1]; // see RULE10
      memReq.wdata <= wrWord; // see RULE9
    end
  end

  // ****************************************
  // Internal program state
  // ****************************************
  // On a context switch or trap the workspace pointer changes only after the vector and saves are done.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pc_ff <= RESET_PC;
      wp_ff <= RESET_WP;
      st_ff <= RESET_ST;
      newWp_ff <= '0;
      newPc_ff <= '0;
      regVal_ff <= '0;
    end else if (done) begin
      case (state_ff)
        S_LINK_WR: pc_ff <= cmd_ff.target; // see RULE1
        S_RD_REG: begin
          regVal_ff <= memRdata;
          if (cmd_ff.op == OP_RET_INDIRECT) pc_ff <= memRdata; // see RULE3
        end
        S_VEC_WP: newWp_ff <= memRdata; // see RULE11
        S_VEC_PC: newPc_ff <= memRdata;
        S_SAVE_ST: begin
          if (cmd_ff.op != OP_TRAP) begin
            wp_ff <= newWp_ff; // see RULE5
            pc_ff <= newPc_ff;
          end
        end
        S_SAVE_SRC: begin
          wp_ff <= newWp_ff; // see RULE14
          pc_ff <= newPc_ff;
        end
        S_RST_ST: st_ff <= memRdata;
        S_RST_PC: pc_ff <= memRdata;
        S_RST_WP: wp_ff <= memRdata; // see RULE7
        default: ;
      endcase
    end
  end

  // ****************************************
  // Operand return and visible outputs
  // ****************************************
  // Byte operands: register mode takes the left byte, memory the addressed
  // half, returned right aligned in the low byte.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      opndData <= '0;
      opndValid <= 1'b0;
    end else begin
      opndValid <= 1'b0;
      if (done && cmd_ff.op == OP_READ_OPND &&
          ((state_ff == S_RD_REG && cmd_ff.mode == MODE_REG) ||
           state_ff == S_RD_OPND)) begin
        opndValid <= 1'b1;
        if (!cmd_ff.isByte) begin
          opndData <= memRdata;
        end else if (state_ff == S_RD_REG || !regVal_ff[0]) begin
          opndData <= {8'h00, memRdata[15:8]}; // see RULE8
        end else begin
          opndData <= {8'h00, memRdata[7:0]}; // see RULE9
        end
      end
    end
  end

  // Idle flag and copies of internal state.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busy_ff <= 1'b0;
      cmdReady <= 1'b1;
      pcOut <= RESET_PC;
      wpOut <= RESET_WP;
      stOut <= RESET_ST;
    end else begin
      busy_ff <= (state_ff != S_IDLE) | cmdValid;
      cmdReady <= (state_ff == S_IDLE) & ~cmdValid & ~busy_ff;
      pcOut <= pc_ff;
      wpOut <= wp_ff;
      stOut <= st_ff;
    end
  end

endmodule
`default_nettype wire

// ---- hdl/wsp_pkg.sv ----
// Purpose: Shared constants and carriers for the workspace call linkage core.
// Assumes: Word-wide memory, byte addresses inside the core.
// Notes: Offsets are byte offsets unless named as a word index.
`default_nettype none
package wsp_pkg;

  // ****************************************
  // Register slots and vectors
  // ****************************************
  localparam logic [3:0] LINK_REG = 4'hb;
  localparam logic [3:0] SAVED_WP_REG = 4'hd;
  localparam logic [3:0] SAVED_PC_REG = 4'he;
  localparam logic [3:0] SAVED_ST_REG = 4'hf;
  localparam logic [15:0] TRAP_VEC_BASE = 16'h0040;
  localparam logic [15:0] TRAP_VEC_STEP = 16'h0004;
  localparam logic [15:0] REG_STRIDE = 16'h0002;
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam logic [15:0] BYTE_STEP = 16'h0001;
  localparam logic [15:0] RESET_WP = 16'h0000;
  localparam logic [15:0] RESET_PC = 16'h0000;
  localparam logic [15:0] RESET_ST = 16'h0000;

  // ****************************************
  // Operations handed to the linkage core
  // ****************************************
  typedef enum logic [2:0] {
    OP_CALL_LINK,
    OP_RET_INDIRECT,
    OP_CTX_CALL,
    OP_TRAP,
    OP_CTX_RETURN,
    OP_READ_OPND
  } op_e;

  // Operand mode of OP_READ_OPND.
  typedef enum logic [1:0] {
    MODE_REG,
    MODE_IND,
    MODE_IND_INC
  } mode_e;

  typedef struct packed {
    op_e op;
    mode_e mode;
    logic isByte;
    logic [3:0] regNum;
    logic [3:0] trapNum;
    logic [15:0] target;
  } cmd_s;

  typedef struct packed {
    logic req;
    logic write;
    logic [14:0] addr;
    logic [15:0] wdata;
  } mem_req_s;

endpackage
`default_nettype wire

// ---- testbench/workspace_call_linkage_chk.sv ----
// Purpose: Port checks of the workspace call linkage core.
// Assumes: The first request of a command comes one or two cycles after
//   the cycle in which the command is taken.
// Notes: The expected first address is latched when a command is taken.
`timescale 1ns/100ps
`default_nettype none
module workspace_call_linkage_chk
  import wsp_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Command port
  input wire cmd_s cmd,
  input wire logic cmdValid,
  input wire logic cmdReady,
  // Memory port
  input wire mem_req_s memReq,
  input wire logic memAck,
  // Visible state
  input wire logic [15:0] wpOut
);
  logic takeQ_ff;
  op_e lastOp_ff;
  logic [15:0] expAdr_ff;
  logic [15:0] nxtAdr;
  logic [15:0] wAdr;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // Byte address that the current request points at.
  assign wAdr = {memReq.addr, 1'b0};

  // First address that a command must touch, worked out at the take.
  always_comb begin
    nxtAdr = wpOut + {11'h000, cmd.regNum, 1'b0};
    case (cmd.op)
      OP_CTX_CALL: nxtAdr = cmd.target;
      OP_TRAP: nxtAdr = 16'h0040 + {10'h000, cmd.trapNum, 2'b00};
      OP_CTX_RETURN: nxtAdr = wpOut + 16'h001e;
      OP_CALL_LINK: nxtAdr = wpOut + 16'h0016;
      default: ;
    endcase
  end

  // Flag one cycle after a take; reset clears it so no stale check runs.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      takeQ_ff <= 1'b0;
    end else begin
      takeQ_ff <= cmdValid && cmdReady;
    end
  end

  // Command data only matters behind the flag, so it needs no reset.
  always_ff @(posedge clk_sys) begin
    if (cmdValid && cmdReady) begin
      lastOp_ff <= cmd.op;
      expAdr_ff <= nxtAdr;
    end
  end

  AST_CALL_WR: assert property (
    takeQ_ff && lastOp_ff == OP_CALL_LINK |-> ##[0:1]
    memReq.req && memReq.write && wAdr == expAdr_ff) else $error("link");
  AST_RET_RD: assert property (
    takeQ_ff && lastOp_ff == OP_RET_INDIRECT |-> ##[0:1]
    memReq.req && !memReq.write && wAdr == expAdr_ff) else $error("ret");
  AST_OPND_RD: assert property (
    takeQ_ff && lastOp_ff == OP_READ_OPND |-> ##[0:1]
    memReq.req && !memReq.write && wAdr == expAdr_ff) else $error("opnd");
  AST_CTX_VEC: assert property (
    takeQ_ff && lastOp_ff == OP_CTX_CALL |-> ##[0:1]
    memReq.req && !memReq.write && wAdr == expAdr_ff) else $error("ctx");
  AST_TRAP_VEC: assert property (
    takeQ_ff && lastOp_ff == OP_TRAP |-> ##[0:1]
    memReq.req && !memReq.write && wAdr == expAdr_ff) else $error("trap");
  AST_CTX_RET: assert property (
    takeQ_ff && lastOp_ff == OP_CTX_RETURN |-> ##[0:1]
    memReq.req && !memReq.write && wAdr == expAdr_ff) else $error("rtn");
  AST_REQ_HOLD: assert property (
    memReq.req && !memAck |=> memReq.req && $stable(memReq))
    else $error("request moved before its answer");
  AST_REQ_DROP: assert property (
    memAck |=> !memReq.req) else $error("request held after answer");
endmodule
`default_nettype wire

// ---- testbench/wsp_mem_model.sv ----
// Purpose: Word memory holding workspaces, vectors and code.
// Assumes: One request at a time, each answered by a one-cycle ack.
// Notes: Read data scrambles outside the ack cycle, like a released bus.
`timescale 1ns/100ps
`default_nettype none
module wsp_mem_model
  import wsp_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Request side
  input wire mem_req_s memReq,
  input wire logic slow,
  output logic memAck,
  output logic [15:0] memRdata
);
  logic [15:0] mem [0:32767];
  logic [1:0] waitCnt;

  initial begin
    memAck = 1'b0;
    memRdata = 16'h0f0f;
    waitCnt = 2'h0;
  end

  // Answer at once or after three waits; words are found from the
  // fifteen address bits alone, there is no byte lane.
  always @(posedge clk_sys) begin
    memAck <= 1'b0;
    memRdata <= ~memRdata;
    if (memReq.req && !memAck) begin
      if (!slow || waitCnt == 2'h3) begin
        memAck <= 1'b1;
        waitCnt <= 2'h0;
        memRdata <= mem[memReq.addr];
        if (memReq.write) begin
          mem[memReq.addr] <= memReq.wdata;
        end
      end else begin
        waitCnt <= waitCnt + 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- testbench/tb_workspace_call_linkage.sv ----
// Purpose: Self-checking bench of the workspace call linkage core.
// Assumes: Memory is preset and inspected through the model's array.
// Notes: Commands wait for cmdReady, so none is issued back to back.
`timescale 1ns/100ps
`default_nettype none
module tb_workspace_call_linkage;
  import wsp_pkg::*;
  logic clk_sys, rst_n, cmdValid, cmdReady, opndValid, memAck, slow;
  cmd_s cmd;
  mem_req_s memReq;
  logic [15:0] opndData, memRdata, pcOut, wpOut, stOut, opLast;
  int num_errors = 0;
  int n_tests = 0;
  int cycles = 0;

  workspace_call_linkage dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
    .cmd(cmd), .cmdValid(cmdValid), .cmdReady(cmdReady),
    .opndData(opndData), .opndValid(opndValid), .memReq(memReq),
    .memAck(memAck), .memRdata(memRdata), .pcOut(pcOut), .wpOut(wpOut),
    .stOut(stOut));
  wsp_mem_model mu (.clk_sys(clk_sys), .memReq(memReq), .slow(slow),
    .memAck(memAck), .memRdata(memRdata));

  // Free-running clock; the cycle ceiling cuts a hang short.
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (opndValid === 1'b1) begin
      opLast <= opndData;
    end
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      close_out();
    end
  end

  task automatic close_out();
    if (num_errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // One-cycle command pulse, then a bounded wait for idle.
  task automatic go(input op_e op, input mode_e md, input logic b,
    input logic [3:0] r, input logic [15:0] t);
    int n = 0;
    @(negedge clk_sys);
    cmd = '{op, md, b, r, r, t};
    cmdValid = 1'b1;
    @(negedge clk_sys);
    cmdValid = 1'b0;
    repeat (2) @(negedge clk_sys);
    while (cmdReady !== 1'b1 && n < 300) begin
      @(negedge clk_sys);
      n++;
    end
    // A command that never finishes ends the run as a failure.
    if (cmdReady !== 1'b1) begin
      num_errors++;
      close_out();
    end
  endtask

  task automatic t_call();
    mu.mem[15'h00b] = 16'hffff;
    go(OP_CALL_LINK, MODE_REG, 1'b0, 4'h0, 16'h0200);
    chk(mu.mem[15'h00b], 16'h0000);
    chk(pcOut, 16'h0200);
    go(OP_CALL_LINK, MODE_REG, 1'b0, 4'h0, 16'h0240);
    chk(mu.mem[15'h00b], 16'h0200);
  endtask

  task automatic t_ctx();
    mu.mem[15'h080] = 16'h0400;
    mu.mem[15'h081] = 16'h0500;
    mu.mem[15'h20d] = 16'hffff;
    slow = 1'b1;
    go(OP_CTX_CALL, MODE_REG, 1'b0, 4'h0, 16'h0100);
    chk(wpOut, 16'h0400);
    chk(pcOut, 16'h0500);
    chk(mu.mem[15'h20d], 16'h0000);
    chk(mu.mem[15'h20e], 16'h0240);
    slow = 1'b0;
  endtask

  // Register, left byte, then auto increment by two and by one.
  task automatic t_opnd();
    mu.mem[15'h203] = 16'ha55a;
    mu.mem[15'h204] = 16'h0600;
    mu.mem[15'h300] = 16'h1234;
    mu.mem[15'h301] = 16'h5678;
    go(OP_READ_OPND, MODE_REG, 1'b0, 4'h3, 16'h0000);
    chk(opLast, 16'ha55a);
    go(OP_READ_OPND, MODE_REG, 1'b1, 4'h3, 16'h0000);
    chk(opLast, 16'h00a5);
    go(OP_READ_OPND, MODE_IND_INC, 1'b0, 4'h4, 16'h0000);
    chk(opLast, 16'h1234);
    chk(mu.mem[15'h204], 16'h0602);
    go(OP_READ_OPND, MODE_IND_INC, 1'b1, 4'h4, 16'h0000);
    chk(opLast, 16'h0056);
    chk(mu.mem[15'h204], 16'h0603);
    go(OP_READ_OPND, MODE_IND, 1'b1, 4'h4, 16'h0000);
    chk(opLast, 16'h0078);
  endtask

  task automatic t_ret();
    mu.mem[15'h20f] = 16'h0003;
    go(OP_RET_INDIRECT, MODE_REG, 1'b0, 4'h4, 16'h0000);
    chk(pcOut, 16'h0603);
    go(OP_CTX_RETURN, MODE_REG, 1'b0, 4'h0, 16'h0000);
    chk(wpOut, 16'h0000);
    chk(pcOut, 16'h0240);
    chk(stOut, 16'h0003);
  endtask

  // Every trap number, each followed by a return to the caller.
  task automatic t_trap();
    logic [15:0] w;
    for (int n = 0; n < 16; n++) begin
      w = {6'h02, n[3:0], 6'h00};
      mu.mem[{10'h001, n[3:0], 1'b0}] = w;
      mu.mem[{10'h001, n[3:0], 1'b1}] = {12'h090, n[3:0]};
      slow = n[0];
      go(OP_TRAP, MODE_REG, 1'b0, n[3:0], 16'h0abc);
      chk(wpOut, w);
      chk(pcOut, {12'h090, n[3:0]});
      chk(mu.mem[w[15:1] + 15'h00b], 16'h0abc);
      go(OP_CTX_RETURN, MODE_REG, 1'b0, 4'h0, 16'h0000);
      chk(pcOut, 16'h0240);
      chk(wpOut, 16'h0000);
    end
  endtask

  initial begin
    rst_n = 1'b0;
    cmdValid = 1'b0;
    cmd = '0;
    slow = 1'b0;
    repeat (4) @(negedge clk_sys);
    rst_n = 1'b1;
    t_call();
    t_ctx();
    t_opnd();
    t_ret();
    t_trap();
    close_out();
  end
endmodule

bind workspace_call_linkage workspace_call_linkage_chk chk_u (
  .clk_sys(clk_sys), .rst_n(rst_n), .cmd(cmd), .cmdValid(cmdValid),
  .cmdReady(cmdReady), .memReq(memReq), .memAck(memAck), .wpOut(wpOut));
`default_nettype wire
